// ===== rtl/ufl_pkg.sv
// Constants for the UART holding, FIFO control and loopback block.
// Assumes a byte-wide host register port on the system clock.
package ufl_pkg;
	// Standard page offsets, reachable while line_control is not the key.
	localparam logic [2:0] A_DATA = 3'h0;
	localparam logic [2:0] A_IER = 3'h1;
	localparam logic [2:0] A_FCR = 3'h2;
	localparam logic [2:0] A_LCR = 3'h3;
	localparam logic [2:0] A_MCR = 3'h4;
	localparam logic [2:0] A_LSR = 3'h5;
	localparam logic [2:0] A_MSR = 3'h6;
	// Enhanced page offsets, reachable while line_control holds the key.
	localparam logic [2:0] A_TTS = 3'h1;
	localparam logic [2:0] A_EFR = 3'h2;
	localparam logic [2:0] A_RXTL = 3'h4;
	localparam logic [2:0] A_TXTL = 3'h5;
	localparam logic [7:0] LCR_KEY = 8'hbf;
	localparam int LCR_DIVISOR_LATCH_ACCESS = 7;
	localparam int EFR_ENH = 4;
	localparam int FCR_EN = 0;
	localparam int FCR_RXRST = 1;
	localparam int FCR_TXRST = 2;
	localparam int FCR_DMA = 3;
	localparam int MCR_LOOP = 4;
	localparam int IER_SLEEP = 4;
	localparam logic [7:0] IER_RST = 8'h00;
	localparam logic [7:0] LCR_RST = 8'h00;
	localparam logic [7:0] MCR_RST = 8'h00;
	localparam logic [7:0] EFR_RST = 8'h00;
	localparam logic [1:0] SEL_RST = 2'h0;
	localparam logic [7:0] TL_RST = 8'h01;
	// Trigger tables, code 00 in the low byte.
	localparam logic [31:0] TX_TAB0 = {4{8'h01}};
	localparam logic [31:0] TX_TAB1 = {8'h1e, 8'h18, 8'h08, 8'h10};
	localparam logic [31:0] TX_TAB2 = {8'h38, 8'h20, 8'h10, 8'h08};
	localparam logic [31:0] RX_TAB0 = {8'h0e, 8'h08, 8'h04, 8'h01};
	localparam logic [31:0] RX_TAB1 = {8'h1c, 8'h18, 8'h10, 8'h08};
	localparam logic [31:0] RX_TAB2 = {8'h3c, 8'h38, 8'h10, 8'h08};
	localparam int CHAR_BITS = 10;
	localparam int TIMEOUT_CHARS = 4;
endpackage

// ===== rtl/ufl_uart.sv
// UART channel: holding paths into FIFOs, interrupt enables, FIFO
// control, DMA request pins and internal loopback, 8N1 framing.
// Assumes the host port is synchronous to clk_sys_i; serial and modem
// pins are asynchronous and are synchronised here.
// Function
// R1 - Loopback ties transmitter to receiver, pins detached
// R2 - Loopback: CTS from DTR, DSR from RTS
// R3 - Loopback: RI and CD from general outputs
// R4 - Write offset zero loads transmit path
// R5 - Host never writes while transmit space low
// R6 - Read offset zero returns oldest byte
// R7 - Standard registers hidden while key loaded
// R8 - Enable bit0: receive data interrupt
// R9 - Enable bit1: transmit level interrupt
// R10 - Enable bit2: receive error interrupt
// R11 - Enable bit3: modem change interrupt
// R12 - Upper enables and triggers need enhanced bit
// R13 - Sleep only when idle; wake on activity
// R14 - Enable bit5: Xoff received interrupt
// R15 - Enable bits6,7: RTS, CTS rising interrupt
// R16 - FIFO control bit0 enables both FIFOs
// R17 - Flush bits empty FIFOs and self-clear
// R18 - DMA mode 0 request pin levels
// R19 - DMA mode 1 request pin levels
// R20 - Transmit trigger tables 00 and 01
// R21 - Transmit trigger table 10, programmable 11
// R22 - Receive trigger table 00, 1 after reset
// R23 - Receive interrupt at trigger, keep filling
// R24 - Receive trigger tables 01, 10, 11
// R25 - Receive time-out after four idle characters
// R26 - Divisor latch access hides data, enables
`timescale 1ns/1ps

module ufl_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	localparam int CW = $clog2(DEPTH) + 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic flush_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [CW-1:0] count_o
);
	// DEPTH must be a power of two so the pointers wrap on their own.
	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-2:0] wp_q, rp_q;
	logic [CW-1:0] cnt_q;
	logic push, pop;

	assign in_ready_o = cnt_q != CW'(DEPTH);
	assign out_valid_o = cnt_q != '0;
	assign out_data_o = mem[rp_q];
	assign count_o = cnt_q;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_q] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else if (flush_i) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + (CW-1)'(push);
			rp_q <= rp_q + (CW-1)'(pop);
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end
endmodule

module ufl_uart #(
	parameter int DEPTH = 128,
	parameter int BIT_CYCLES = 16,
	parameter logic [7:0] XOFF_CHAR = 8'h13
) (
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	input wire logic rx_i,
	output logic tx_o,
	input wire logic cts_n_i,
	input wire logic dsr_n_i,
	input wire logic ri_n_i,
	input wire logic cd_n_i,
	output logic rts_n_o,
	output logic dtr_n_o,
	output logic irq_o,
	output logic tx_dma_request_n_o,
	output logic rx_dma_request_n_o,
	output logic sleep_o
);
	localparam int CW = $clog2(DEPTH) + 1;
	localparam int TOUT_CYCLES =
		ufl_pkg::TIMEOUT_CHARS * ufl_pkg::CHAR_BITS * BIT_CYCLES;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufl_rx_t;

	logic [1:0] rst_s_q;
	logic rst_n;
	logic [4:0] pin_m_q, pin_s_q;
	logic [7:0] ier_q, lcr_q, mcr_q, efr_q, rxtl_q, txtl_q;
	logic fifo_en_q, dma_q, rx_flush_q, tx_flush_q;
	logic [1:0] txsel_q, rxsel_q, tts_q;
	logic enh_page, divisor_latch_access, enh, loop;
	logic wr_thr, rd_rhr, wr_ier, wr_fcr, rd_lsr, rd_msr, rd_isr;
	logic tx_in_rdy, tx_vld, tx_take, rx_in_rdy, rx_vld;
	logic tx_space, rx_space, rx_push;
	logic [7:0] tx_data, rx_data, tx_trig, rx_trig, rd_d;
	logic [CW-1:0] tx_cnt, rx_cnt;
	logic tx_busy_q, tx_ser_q;
	logic [8:0] tx_sh_q;
	logic [3:0] tx_bit_q, rx_bit_q;
	logic [15:0] tx_div_q, rx_div_q, tout_cnt_q;
	ufl_rx_t rx_st_q;
	logic [7:0] rx_sh_q;
	logic rx_done_q, rx_ferr_q, rx_line;
	logic ovr_q, fe_q, brk_q, xoff_q, rts_ev_q, cts_ev_q, tout_q;
	logic [3:0] modem, modem_q, mdelta_q;
	logic cts_pin_q, rts_pin_q, rxdma_q, pend;
	logic rx_lvl, tx_lvl;

	function automatic logic [7:0] trig_level(input logic [1:0] tab,
		input logic [1:0] code, input logic rx, input logic [7:0] prog);
		logic [31:0] row;
		row = '0;
		unique case (tab)
			2'h0: row = rx ? ufl_pkg::RX_TAB0 : ufl_pkg::TX_TAB0;
			2'h1: row = rx ? ufl_pkg::RX_TAB1 : ufl_pkg::TX_TAB1;
			2'h2: row = rx ? ufl_pkg::RX_TAB2 : ufl_pkg::TX_TAB2;
			2'h3: row = {4{prog}};
		endcase
		trig_level = row[{code, 3'h0} +: 8];
	endfunction

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_s_q <= 2'h0;
		end else begin
			rst_s_q <= {rst_s_q[0], 1'b1};
		end
	end
	assign rst_n = rst_s_q[1];

	// Pin order: cd, ri, dsr, cts, rx; idle level is high on all.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_m_q <= 5'h1f;
			pin_s_q <= 5'h1f;
		end else begin
			pin_m_q <= {cd_n_i, ri_n_i, dsr_n_i, cts_n_i, rx_i};
			pin_s_q <= pin_m_q;
		end
	end

	assign enh_page = lcr_q == ufl_pkg::LCR_KEY;
	assign divisor_latch_access = lcr_q[ufl_pkg::LCR_DIVISOR_LATCH_ACCESS];
	assign enh = efr_q[ufl_pkg::EFR_ENH];
	assign loop = mcr_q[ufl_pkg::MCR_LOOP];
	assign wr_thr = wr_en_i && addr_i == ufl_pkg::A_DATA && !enh_page && !divisor_latch_access; // R4 R7 R26
	assign rd_rhr = rd_en_i && addr_i == ufl_pkg::A_DATA && !enh_page && !divisor_latch_access; // R6 R7 R26
	assign wr_ier = wr_en_i && addr_i == ufl_pkg::A_IER && !enh_page && !divisor_latch_access; // R7 R26
	assign wr_fcr = wr_en_i && addr_i == ufl_pkg::A_FCR && !enh_page; // R7
	assign rd_isr = rd_en_i && addr_i == ufl_pkg::A_FCR && !enh_page;
	assign rd_lsr = rd_en_i && addr_i == ufl_pkg::A_LSR && !enh_page;
	assign rd_msr = rd_en_i && addr_i == ufl_pkg::A_MSR && !enh_page;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ier_q <= ufl_pkg::IER_RST;
		end else if (wr_ier) begin
			ier_q <= enh ? wdata_i : {ier_q[7:4], wdata_i[3:0]}; // R12
		end
	end

	// A write with the enable bit low only disables; other bits are kept.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			fifo_en_q <= 1'b0;
			dma_q <= 1'b0;
			txsel_q <= ufl_pkg::SEL_RST;
			rxsel_q <= ufl_pkg::SEL_RST;
		end else if (wr_fcr) begin
			fifo_en_q <= wdata_i[ufl_pkg::FCR_EN]; // R16
			if (wdata_i[ufl_pkg::FCR_EN]) begin
				dma_q <= wdata_i[ufl_pkg::FCR_DMA];
				if (enh) begin
					txsel_q <= wdata_i[5:4]; // R12
					rxsel_q <= wdata_i[7:6];
				end
			end
		end
	end

	// Flush requests last one cycle, which is all the FIFO needs.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_flush_q <= 1'b0;
			tx_flush_q <= 1'b0;
		end else begin
			rx_flush_q <= wr_fcr && wdata_i[ufl_pkg::FCR_EN] &&
				wdata_i[ufl_pkg::FCR_RXRST]; // R17
			tx_flush_q <= wr_fcr && wdata_i[ufl_pkg::FCR_EN] &&
				wdata_i[ufl_pkg::FCR_TXRST]; // R17
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			lcr_q <= ufl_pkg::LCR_RST;
			mcr_q <= ufl_pkg::MCR_RST;
			efr_q <= ufl_pkg::EFR_RST;
			tts_q <= ufl_pkg::SEL_RST;
			rxtl_q <= ufl_pkg::TL_RST;
			txtl_q <= ufl_pkg::TL_RST;
		end else if (wr_en_i) begin
			if (addr_i == ufl_pkg::A_LCR) begin
				lcr_q <= wdata_i;
			end else if (!enh_page && addr_i == ufl_pkg::A_MCR) begin
				mcr_q <= enh ? wdata_i : {mcr_q[7:5], wdata_i[4:0]};
			end else if (enh_page && addr_i == ufl_pkg::A_EFR) begin
				efr_q <= wdata_i;
			end else if (enh_page && addr_i == ufl_pkg::A_TTS) begin
				tts_q <= wdata_i[5:4];
			end else if (enh_page && addr_i == ufl_pkg::A_RXTL) begin
				rxtl_q <= wdata_i;
			end else if (enh_page && addr_i == ufl_pkg::A_TXTL) begin
				txtl_q <= wdata_i;
			end
		end
	end

	assign tx_trig = trig_level(tts_q, txsel_q, 1'b0, txtl_q); // R20 R21
	assign rx_trig = trig_level(tts_q, rxsel_q, 1'b1, rxtl_q); // R22 R24

	// Without FIFOs each path behaves as a single holding register.
	assign tx_space = fifo_en_q ? tx_in_rdy : tx_cnt == '0;
	assign rx_space = fifo_en_q ? rx_in_rdy : rx_cnt == '0;
	assign rx_push = rx_done_q && rx_space;
	assign tx_take = !tx_busy_q;

	ufl_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_fifo (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n),
		.flush_i(tx_flush_q),
		.in_valid_i(wr_thr && tx_space), // R4 R5
		.in_ready_o(tx_in_rdy),
		.in_data_i(wdata_i),
		.out_valid_o(tx_vld),
		.out_ready_i(tx_take),
		.out_data_o(tx_data),
		.count_o(tx_cnt)
	);

	ufl_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.clk_i(clk_sys_i),
		.rst_n_i(rst_n),
		.flush_i(rx_flush_q),
		.in_valid_i(rx_push), // R23
		.in_ready_o(rx_in_rdy),
		.in_data_i(rx_sh_q),
		.out_valid_o(rx_vld),
		.out_ready_i(rd_rhr), // R6
		.out_data_o(rx_data),
		.count_o(rx_cnt)
	);

	// Transmitter: start, eight data bits LSB first, one stop bit.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_busy_q <= 1'b0;
			tx_ser_q <= 1'b1;
			tx_sh_q <= '1;
			tx_bit_q <= '0;
			tx_div_q <= '0;
		end else if (!tx_busy_q) begin
			if (tx_vld) begin
				tx_busy_q <= 1'b1;
				tx_ser_q <= 1'b0;
				tx_sh_q <= {1'b1, tx_data};
				tx_bit_q <= '0;
				tx_div_q <= '0;
			end
		end else if (tx_div_q == 16'(BIT_CYCLES - 1)) begin
			tx_div_q <= '0;
			if (tx_bit_q == 4'(ufl_pkg::CHAR_BITS - 1)) begin
				tx_busy_q <= 1'b0;
			end else begin
				tx_ser_q <= tx_sh_q[0];
				tx_sh_q <= {1'b1, tx_sh_q[8:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
			end
		end else begin
			tx_div_q <= tx_div_q + 16'h1;
		end
	end

	assign rx_line = loop ? tx_ser_q : pin_s_q[0]; // R1

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= RX_IDLE;
			rx_sh_q <= '0;
			rx_bit_q <= '0;
			rx_div_q <= '0;
			rx_done_q <= 1'b0;
			rx_ferr_q <= 1'b0;
		end else begin
			rx_done_q <= 1'b0;
			rx_div_q <= rx_div_q + 16'h1;
			unique case (rx_st_q)
				RX_IDLE: begin
					rx_div_q <= '0;
					if (!rx_line) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					if (rx_div_q == 16'(BIT_CYCLES / 2)) begin
						rx_div_q <= '0;
						rx_bit_q <= '0;
						rx_st_q <= rx_line ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (rx_div_q == 16'(BIT_CYCLES - 1)) begin
						rx_div_q <= '0;
						rx_sh_q <= {rx_line, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == 4'h7) begin
							rx_st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (rx_div_q == 16'(BIT_CYCLES - 1)) begin
						rx_done_q <= 1'b1;
						rx_ferr_q <= !rx_line;
						rx_st_q <= RX_IDLE;
					end
				end
			endcase
		end
	end

	// Internal modem inputs, active high: cd, ri, dsr, cts.
	assign modem = loop ? mcr_q[3:0] : ~pin_s_q[4:1]; // R2 R3

	// Sticky flags: a set in the same cycle as the clearing read wins.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ovr_q <= 1'b0;
			fe_q <= 1'b0;
			brk_q <= 1'b0;
		end else begin
			ovr_q <= (rx_done_q && !rx_space) || (ovr_q && !rd_lsr);
			fe_q <= (rx_done_q && rx_ferr_q) || (fe_q && !rd_lsr);
			brk_q <= (rx_done_q && rx_ferr_q && rx_sh_q == '0) ||
				(brk_q && !rd_lsr);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			xoff_q <= 1'b0;
		end else begin
			xoff_q <= (rx_done_q && !rx_ferr_q && rx_sh_q == XOFF_CHAR) ||
				(xoff_q && !rd_isr); // R14
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			modem_q <= '0;
			mdelta_q <= '0;
			cts_pin_q <= 1'b1;
			rts_pin_q <= 1'b1;
			rts_ev_q <= 1'b0;
			cts_ev_q <= 1'b0;
		end else begin
			modem_q <= modem;
			mdelta_q <= (modem ^ modem_q) | (mdelta_q & {4{!rd_msr}}); // R11
			cts_pin_q <= pin_s_q[1];
			rts_pin_q <= rts_n_o;
			rts_ev_q <= (rts_n_o && !rts_pin_q) || (rts_ev_q && !rd_msr); // R15
			cts_ev_q <= (pin_s_q[1] && !cts_pin_q) ||
				(cts_ev_q && !rd_msr); // R15
		end
	end

	// Idle time-out: any push or pop restarts the character-time count.
	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tout_cnt_q <= '0;
			tout_q <= 1'b0;
		end else if (rx_cnt == '0 || rx_push || rd_rhr) begin
			tout_cnt_q <= '0;
			tout_q <= 1'b0;
		end else if (tout_cnt_q == 16'(TOUT_CYCLES - 1)) begin
			tout_q <= tout_q || rx_cnt < CW'(rx_trig); // R25
		end else begin
			tout_cnt_q <= tout_cnt_q + 16'h1;
		end
	end

	assign rx_lvl = fifo_en_q ? (rx_cnt >= CW'(rx_trig) || tout_q) :
		rx_cnt != '0; // R8 R23
	assign tx_lvl = fifo_en_q ? tx_cnt < CW'(tx_trig) : tx_cnt == '0; // R9
	assign pend = (ier_q[0] && rx_lvl) || (ier_q[1] && tx_lvl) ||
		(ier_q[2] && (ovr_q || fe_q || brk_q)) || // R10
		(ier_q[3] && mdelta_q != '0) || (ier_q[5] && xoff_q) ||
		(ier_q[6] && rts_ev_q) || (ier_q[7] && cts_ev_q);

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			irq_o <= 1'b0;
			sleep_o <= 1'b0;
		end else begin
			irq_o <= pend;
			if (wr_thr || !rx_line || modem != modem_q) begin
				sleep_o <= 1'b0; // R13
			end else if (ier_q[ufl_pkg::IER_SLEEP] && !pend &&
				rx_st_q == RX_IDLE && !tx_busy_q && tx_cnt == '0) begin
				sleep_o <= 1'b1; // R13
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			tx_o <= 1'b1;
			rts_n_o <= 1'b1;
			dtr_n_o <= 1'b1;
			tx_dma_request_n_o <= 1'b0;
			rx_dma_request_n_o <= 1'b1;
			rxdma_q <= 1'b1;
		end else begin
			tx_o <= loop || tx_ser_q; // R1
			rts_n_o <= loop || !mcr_q[1];
			dtr_n_o <= loop || !mcr_q[0];
			if (rx_cnt == '0) begin
				rxdma_q <= 1'b1;
			end else if (rx_cnt >= CW'(rx_trig) || tout_q) begin
				rxdma_q <= 1'b0; // R19
			end
			if (dma_q && fifo_en_q) begin
				tx_dma_request_n_o <= !tx_in_rdy; // R19
				rx_dma_request_n_o <= rxdma_q;
			end else begin
				tx_dma_request_n_o <= tx_cnt != '0; // R18
				rx_dma_request_n_o <= rx_cnt == '0; // R18
			end
		end
	end

	always_comb begin
		rd_d = 8'h00;
		if (enh_page) begin
			unique case (addr_i)
				ufl_pkg::A_TTS: rd_d = {2'h0, tts_q, 4'h0};
				ufl_pkg::A_EFR: rd_d = efr_q;
				ufl_pkg::A_LCR: rd_d = lcr_q;
				ufl_pkg::A_RXTL: rd_d = rxtl_q;
				ufl_pkg::A_TXTL: rd_d = txtl_q;
				default: rd_d = 8'h00;
			endcase
		end else begin
			unique case (addr_i)
				ufl_pkg::A_DATA: rd_d = divisor_latch_access ? 8'h00 : rx_data; // R6
				ufl_pkg::A_IER: rd_d = divisor_latch_access ? 8'h00 :
					{ier_q[7:4] & {4{enh}}, ier_q[3:0]}; // R12
				ufl_pkg::A_FCR: rd_d = {{2{fifo_en_q}}, 5'h00, !pend};
				ufl_pkg::A_LCR: rd_d = lcr_q;
				ufl_pkg::A_MCR: rd_d = mcr_q;
				ufl_pkg::A_LSR: rd_d = {ovr_q || fe_q || brk_q,
					tx_cnt == '0 && !tx_busy_q, tx_space, brk_q, fe_q,
					1'b0, ovr_q, rx_vld}; // R6
				ufl_pkg::A_MSR: rd_d = {modem, mdelta_q};
				default: rd_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			rdata_o <= 8'h00;
		end else if (rd_en_i) begin
			rdata_o <= rd_d;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n);

	loop_tx_idle_a: assert property (loop && $past(loop) |-> tx_o) // R1
		else $error("tx pin not idle in loopback");
	loop_modem_a: assert property (loop |=> $past(loop) && // R2
		modem_q[1:0] == $past(mcr_q[1:0]))
		else $error("loopback cts or dsr wrong");
	thr_load_a: assert property (wr_thr && tx_space && !tx_take && // R4
		!tx_flush_q |=> tx_cnt == $past(tx_cnt) + CW'(1))
		else $error("transmit write not stored");
	rx_ready_a: assert property (rd_lsr |=> // R6
		rdata_o[0] == ($past(rx_cnt) != '0))
		else $error("data ready bit wrong");
	key_lock_a: assert property (wr_en_i && enh_page |=> // R7
		ier_q == $past(ier_q))
		else $error("enable register written under key");
	enh_gate_a: assert property (wr_ier && !enh |=> // R12
		ier_q[7:4] == $past(ier_q[7:4]))
		else $error("upper enables written without enhanced bit");
	flush_rx_a: assert property (wr_fcr && wdata_i[0] && wdata_i[1] // R17
		|=> rx_flush_q ##1 !rx_flush_q && rx_cnt <= CW'(1))
		else $error("receive flush did not empty");
	dma0_tx_a: assert property (!dma_q ##1 !$past(dma_q) |-> // R18
		tx_dma_request_n_o == ($past(tx_cnt) != '0))
		else $error("transmit request pin wrong in mode 0");
	irq_rx_a: assert property (ier_q[0] && fifo_en_q && // R8
		rx_cnt >= CW'(rx_trig) |=> irq_o)
		else $error("receive trigger did not interrupt");
endmodule

// ===== verification/ufl_line_model.sv
// Far-end serial peer for the UART: sends and decodes 8N1 frames.
// Assumes BIT clk_i cycles per bit on both ends and an idle-high line.
`timescale 1ns/1ps
module ufl_line_model #(
	parameter int BIT = 4
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o,
	output logic [7:0] byte_o,
	output logic stb_o
);
	logic [9:0] frm;
	logic stop;
	initial begin
		line_o = 1'b1;
		byte_o = 8'h00;
		stb_o = 1'b0;
	end
	// Start bit, eight data bits LSB first, then one stop bit.
	task automatic send(input logic [7:0] b);
		frm = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_i);
			line_o = frm[i];
			repeat (BIT - 1) @(negedge clk_i);
		end
		@(negedge clk_i);
	endtask
	// A frame whose stop bit reads low is dropped as a framing fault.
	always begin
		@(negedge line_i);
		repeat (BIT / 2) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge clk_i);
			byte_o[i] = line_i;
		end
		repeat (BIT) @(posedge clk_i);
		stop = line_i;
		@(negedge clk_i);
		stb_o = stop;
		@(negedge clk_i);
		stb_o = 1'b0;
	end
endmodule

// ===== verification/ufl_uart_tb_top.sv
// Self-checking bench for the UART holding, FIFO and loopback block.
// Assumes the line model on the serial pins uses the same bit time.
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin \
	error_cnt++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module ufl_uart_tb_top;
	localparam int BITC = 4;
	localparam logic [7:0] XOFF = 8'h13;
	logic clk, rst_n, wr, rd, jam, lp, txlow, rd_seen, pline, stb, full;
	logic [2:0] addr;
	logic [7:0] wd, rdata, pbyte, d, v, px;
	logic [7:0] bs[4];
	logic rx, tx, cts_n, dsr_n, ri_n, cd_n, rts_n, dtr_n;
	logic irq, txd_n, rxd_n, slp;
	logic [15:0] e;
	logic [15:0] rq[$];
	logic [7:0] tq[$];
	int error_cnt = 0;
	int compares = 0;
	int seed = 18;
	assign rx = jam ? 1'b0 : pline;
	ufl_uart #(.DEPTH(8), .BIT_CYCLES(BITC), .XOFF_CHAR(XOFF)) u_ufl_uart (
		.clk_sys_i(clk), .arst_n_i(rst_n), .wr_en_i(wr), .rd_en_i(rd),
		.addr_i(addr), .wdata_i(wd), .rdata_o(rdata), .rx_i(rx),
		.tx_o(tx), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ri_n_i(ri_n),
		.cd_n_i(cd_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_o(irq),
		.tx_dma_request_n_o(txd_n), .rx_dma_request_n_o(rxd_n),
		.sleep_o(slp));
	ufl_line_model #(.BIT(BITC)) u_ufl_line_model (.clk_i(clk),
		.line_i(tx), .line_o(pline), .byte_o(pbyte), .stb_o(stb));
	task automatic results;
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr_t(input logic [2:0] a, input logic [7:0] dv);
		@(negedge clk);
		wr = 1'b1;
		addr = a;
		wd = dv;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Every read notes its expectation; a zero mask marks a plain poll.
	task automatic rd_t(input logic [2:0] a, input logic [7:0] ex,
		input logic [7:0] m);
		rq.push_back({ex, m});
		@(negedge clk);
		rd = 1'b1;
		addr = a;
		@(negedge clk);
		rd = 1'b0;
		v = rdata;
	endtask
	task automatic settle;
		repeat (6) @(negedge clk);
	endtask
	task automatic wait_lsr(input logic [7:0] m);
		for (int i = 0; i < 300; i++) begin
			rd_t(ufl_pkg::A_LSR, 8'h00, 8'h00);
			if ((v & m) == m) break;
		end
		`CHK(v & m, m)
	endtask
	always @(posedge clk) begin
		if (rd_seen) begin
			e = rq.pop_front();
			`CHK(rdata & e[7:0], e[15:8] & e[7:0])
		end
		rd_seen = rd;
		if (stb && tq.size() > 0) begin
			px = tq.pop_front();
			`CHK(pbyte, px)
		end
		if (lp && !tx) txlow = 1'b1;
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// The run needs well under two thousand cycles; this bound is far beyond it.
	initial begin
		repeat (50000) @(posedge clk);
		error_cnt++;
		results();
	end
	initial begin
		{rst_n, wr, rd, jam, lp, txlow, rd_seen} = 7'h00;
		{cts_n, dsr_n, ri_n, cd_n} = 4'hf;
		addr = 3'h0;
		wd = 8'h00;
		repeat (20) @(negedge clk);
		`CHK({rdata, tx, rts_n, dtr_n, irq}, 12'h00e)
		`CHK({txd_n, rxd_n, slp}, 3'b010)
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		rd_t(ufl_pkg::A_IER, 8'h00, 8'hff);
		rd_t(3'h7, 8'h00, 8'hff);
		wr_t(ufl_pkg::A_IER, 8'hff);
		rd_t(ufl_pkg::A_IER, 8'h0f, 8'hff);
		wr_t(ufl_pkg::A_LCR, ufl_pkg::LCR_KEY);
		rd_t(ufl_pkg::A_TTS, 8'h00, 8'h0f);
		wr_t(ufl_pkg::A_EFR, 8'h10);
		wr_t(ufl_pkg::A_LCR, 8'h00);
		wr_t(ufl_pkg::A_IER, 8'hef);
		rd_t(ufl_pkg::A_IER, 8'hef, 8'hff);
		wr_t(ufl_pkg::A_LCR, 8'h80);
		rd_t(ufl_pkg::A_IER, 8'h00, 8'hff);
		wr_t(ufl_pkg::A_LCR, 8'h00);
		wr_t(ufl_pkg::A_FCR, 8'h01);
		rd_t(ufl_pkg::A_FCR, 8'hc0, 8'hc0);
		wr_t(ufl_pkg::A_IER, 8'h08);
		rd_t(ufl_pkg::A_MSR, 8'h00, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		cts_n = 1'b0;
		settle();
		`CHK(irq, 1'b1)
		wr_t(ufl_pkg::A_IER, 8'h00);
		// Outside pins all asserted so that loopback states must differ.
		{cts_n, dsr_n, ri_n, cd_n} = 4'h0;
		wr_t(ufl_pkg::A_MCR, 8'h15);
		lp = 1'b1;
		jam = 1'b1;
		settle();
		`CHK({rts_n, dtr_n, tx}, 3'b111)
		rd_t(ufl_pkg::A_MSR, 8'h50, 8'hf0);
		wr_t(ufl_pkg::A_MCR, 8'h1a);
		rd_t(ufl_pkg::A_MSR, 8'ha0, 8'hf0);
		d = 8'($random(seed));
		wr_t(ufl_pkg::A_DATA, d);
		wait_lsr(8'h01);
		rd_t(ufl_pkg::A_DATA, d, 8'hff);
		`CHK(txlow, 1'b0)
		wr_t(ufl_pkg::A_MCR, 8'h00);
		{lp, jam} = 2'b00;
		{cts_n, dsr_n, ri_n, cd_n} = 4'hf;
		// The cts pin has just risen, so its enabled event must interrupt.
		wr_t(ufl_pkg::A_IER, 8'h80);
		settle();
		`CHK(irq, 1'b1)
		rd_t(ufl_pkg::A_MSR, 8'h00, 8'h00);
		settle();
		`CHK(irq, 1'b0)
		wr_t(ufl_pkg::A_IER, 8'h00);
		// Two bytes, so that one waits in the FIFO while the other is sent.
		for (int i = 0; i < 2; i++) begin
			d = 8'($random(seed));
			tq.push_back(d);
			wr_t(ufl_pkg::A_DATA, d);
		end
		settle();
		`CHK(txd_n, 1'b1)
		wait_lsr(8'h40);
		`CHK(txd_n, 1'b0)
		d = 8'($random(seed));
		u_ufl_line_model.send(d);
		settle();
		`CHK(rxd_n, 1'b0)
		rd_t(ufl_pkg::A_DATA, d, 8'hff);
		settle();
		`CHK(rxd_n, 1'b1)
		wr_t(ufl_pkg::A_FCR, 8'h49);
		wr_t(ufl_pkg::A_IER, 8'h01);
		for (int i = 0; i < 4; i++) begin
			bs[i] = 8'($random(seed));
			u_ufl_line_model.send(bs[i]);
			settle();
			`CHK({irq, rxd_n}, (i == 3) ? 2'b10 : 2'b01)
		end
		for (int i = 0; i < 4; i++) begin
			rd_t(ufl_pkg::A_DATA, bs[i], 8'hff);
		end
		settle();
		`CHK({irq, rxd_n}, 2'b01)
		u_ufl_line_model.send(bs[0]);
		settle();
		`CHK({irq, rxd_n}, 2'b01)
		repeat (4 * 10 * BITC + 20) @(negedge clk);
		`CHK({irq, rxd_n}, 2'b10)
		rd_t(ufl_pkg::A_DATA, bs[0], 8'hff);
		wr_t(ufl_pkg::A_IER, 8'h00);
		u_ufl_line_model.send(bs[1]);
		settle();
		wr_t(ufl_pkg::A_FCR, 8'h4b);
		settle();
		rd_t(ufl_pkg::A_LSR, 8'h00, 8'h01);
		rd_t(ufl_pkg::A_FCR, 8'hc0, 8'hc0);
		wr_t(ufl_pkg::A_IER, 8'h20);
		u_ufl_line_model.send(XOFF);
		settle();
		`CHK(irq, 1'b1)
		rd_t(ufl_pkg::A_FCR, 8'hc0, 8'hff);
		rd_t(ufl_pkg::A_DATA, XOFF, 8'hff);
		settle();
		`CHK(irq, 1'b0)
		wr_t(ufl_pkg::A_IER, 8'h00);
		wr_t(ufl_pkg::A_FCR, 8'h09);
		full = 1'b0;
		for (int i = 0; i < 20; i++) begin
			rd_t(ufl_pkg::A_LSR, 8'h00, 8'h00);
			if (!v[5]) begin
				full = 1'b1;
				break;
			end
			wr_t(ufl_pkg::A_DATA, 8'($random(seed)));
		end
		`CHK(full, 1'b1)
		wr_t(ufl_pkg::A_IER, 8'h02);
		settle();
		`CHK({irq, txd_n}, 2'b01)
		wr_t(ufl_pkg::A_FCR, 8'h0d);
		settle();
		rd_t(ufl_pkg::A_LSR, 8'h20, 8'h60);
		`CHK({irq, txd_n}, 2'b10)
		wait_lsr(8'h40);
		wr_t(ufl_pkg::A_IER, 8'h12);
		settle();
		`CHK({irq, slp}, 2'b10)
		wr_t(ufl_pkg::A_IER, 8'h10);
		settle();
		`CHK(slp, 1'b1)
		d = 8'($random(seed));
		tq.push_back(d);
		wr_t(ufl_pkg::A_DATA, d);
		settle();
		`CHK(slp, 1'b0)
		wait_lsr(8'h40);
		wr_t(ufl_pkg::A_IER, 8'h00);
		wr_t(ufl_pkg::A_FCR, 8'h00);
		rd_t(ufl_pkg::A_FCR, 8'h00, 8'hc0);
		// Without FIFOs a second byte before any read must overrun.
		wr_t(ufl_pkg::A_IER, 8'h04);
		u_ufl_line_model.send(bs[1]);
		u_ufl_line_model.send(bs[2]);
		settle();
		`CHK(irq, 1'b1)
		rd_t(ufl_pkg::A_LSR, 8'h83, 8'h83);
		rd_t(ufl_pkg::A_DATA, bs[1], 8'hff);
		settle();
		`CHK(irq, 1'b0)
		settle();
		`CHK(tq.size(), 0)
		results();
	end
endmodule
